// file: logic/phpt_host_port.sv
// Purpose: strobe-driven 8-bit register port of a palette DAC
// Assumes: strobe and bus are asynchronous, both pass two flip-flops
// Notes: reads are answered from a register loaded at the strobe fall
`timescale 1ns/100ps
`default_nettype none
module phpt_host_port
(
    input wire logic clk,
    input wire logic rst,
    input wire logic select_n,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe,
    input wire logic [7:0] pixel_index,
    input wire logic pixel_indexed8,
    output logic [7:0] lut_index
);
    // ==========================================================
    // synchronisers
    logic sel_q1_reg;
    logic sel_s_reg;
    logic sel_d_reg;
    logic [7:0] ad_q1_reg;
    logic [7:0] ad_s_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_q1_reg <= 1'b1;
            sel_s_reg <= 1'b1;
            sel_d_reg <= 1'b1;
            ad_q1_reg <= 8'h00;
            ad_s_reg <= 8'h00;
        end
        else
        begin
            sel_q1_reg <= select_n;
            sel_s_reg <= sel_q1_reg;
            sel_d_reg <= sel_s_reg;
            ad_q1_reg <= ad_in;
            ad_s_reg <= ad_q1_reg;
        end
    end

    // ==========================================================
    // cycle decode
    wire sel_fall = sel_d_reg & ~sel_s_reg;
    wire sel_rise = ~sel_d_reg & sel_s_reg;
    logic cyc_reg;
    logic dir_reg;
    logic [3:0] addr_reg;
    logic [7:0] mask_reg;
    logic [7:0] wr_idx_reg;
    logic [7:0] rd_idx_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] lut_index_reg;
    phpt_pkg::phpt_comp_t comp_reg;
    phpt_lut_if lut ();

    function automatic logic is_reg(input logic [3:0] a, input logic [3:0] code);
        is_reg = (a == code);
    endfunction

    // address and direction bits count at the strobe fall, write data at the rise
    wire [3:0] fall_addr = ad_s_reg[phpt_pkg::ADDR_MSB:0];
    wire fall_read = ad_s_reg[phpt_pkg::DIR_BIT];
    wire end_wr = sel_rise & cyc_reg & ~dir_reg;
    wire start_rd = sel_fall & fall_read;
    wire wr_widx = end_wr & is_reg(addr_reg, phpt_pkg::REG_WR_INDEX);
    wire wr_color = end_wr & is_reg(addr_reg, phpt_pkg::REG_COLOR);
    wire wr_mask = end_wr & is_reg(addr_reg, phpt_pkg::REG_MASK);
    wire wr_ridx = end_wr & is_reg(addr_reg, phpt_pkg::REG_RD_INDEX);
    wire rd_color = start_rd & is_reg(fall_addr, phpt_pkg::REG_COLOR);
    wire last_comp = (comp_reg == phpt_pkg::COMP_BLUE);
    wire [7:0] rd_sel =
        is_reg(fall_addr, phpt_pkg::REG_WR_INDEX) ? wr_idx_reg :
        is_reg(fall_addr, phpt_pkg::REG_COLOR) ? lut.rd_data :
        is_reg(fall_addr, phpt_pkg::REG_MASK) ? mask_reg :
        is_reg(fall_addr, phpt_pkg::REG_RD_INDEX) ? rd_idx_reg :
        phpt_pkg::READ_ZERO;

    // ==========================================================
    // strobe, direction and address capture
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cyc_reg <= 1'b0;
            dir_reg <= 1'b0;
            addr_reg <= 4'h0;
            rd_data_reg <= 8'h00;
        end
        else if (sel_fall)
        begin
            cyc_reg <= 1'b1;
            dir_reg <= fall_read;
            addr_reg <= fall_addr;
            rd_data_reg <= rd_sel;
        end
        else if (sel_rise)
        begin
            cyc_reg <= 1'b0;
        end
    end

    // drive only inside a read cycle; turn-off follows the strobe rise
    assign ad_oe = cyc_reg & dir_reg & ~sel_s_reg;
    assign ad_out = rd_data_reg;

    // ==========================================================
    // mask register and component counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mask_reg <= phpt_pkg::MASK_RESET;
            comp_reg <= phpt_pkg::COMP_RED;
            lut_index_reg <= 8'h00;
        end
        else
        begin
            if (wr_mask)
            begin
                mask_reg <= ad_s_reg;
            end
            if (wr_widx || wr_ridx)
            begin
                comp_reg <= phpt_pkg::COMP_RED;
            end
            else if (wr_color || rd_color)
            begin
                case (comp_reg)
                    phpt_pkg::COMP_RED: comp_reg <= phpt_pkg::COMP_GREEN;
                    phpt_pkg::COMP_GREEN: comp_reg <= phpt_pkg::COMP_BLUE;
                    default: comp_reg <= phpt_pkg::COMP_RED;
                endcase
            end
            lut_index_reg <= pixel_indexed8 ? (pixel_index & mask_reg) : pixel_index;
        end
    end

    assign lut_index = lut_index_reg;

    // ==========================================================
    // index registers: no reset, they survive power-on and soft reset
    always_ff @(posedge clk)
    begin
        if (wr_widx)
        begin
            wr_idx_reg <= ad_s_reg;
        end
        else if (wr_color && last_comp)
        begin
            wr_idx_reg <= wr_idx_reg + 8'h01;
        end
        if (wr_ridx)
        begin
            rd_idx_reg <= ad_s_reg;
        end
        else if (rd_color && last_comp)
        begin
            rd_idx_reg <= rd_idx_reg + 8'h01;
        end
    end

    // ==========================================================
    // table access; read address is pre-fetched, hence the recovery demand
    assign lut.wr_en = wr_color;
    assign lut.wr_addr = {wr_idx_reg, comp_reg};
    assign lut.wr_data = ad_s_reg;
    assign lut.rd_addr = {rd_idx_reg, comp_reg};

    phpt_lut_mem u_lut
    (
        .clk(clk),
        .lut(lut)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_addr;
        sel_fall |=> addr_reg == $past(ad_s_reg[phpt_pkg::ADDR_MSB:0]);
    endproperty
    a_addr: assert property (p_addr) else $error("address not latched");

    property p_dir;
        sel_fall |=> dir_reg == $past(ad_s_reg[phpt_pkg::DIR_BIT]) && cyc_reg;
    endproperty
    a_dir: assert property (p_dir) else $error("direction not latched");

    // legal strobes stay low for two samples, so the answer is up one cycle later
    property p_oe;
        sel_fall |=> ad_oe == $past(fall_read);
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven outside read");

    property p_mask;
        wr_mask |=> mask_reg == $past(ad_s_reg);
    endproperty
    a_mask: assert property (p_mask) else $error("mask write lost");

    property p_mask_rst;
        @(posedge clk) disable iff (1'b0) rst |-> mask_reg == phpt_pkg::MASK_RESET;
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask reset value");

    sequence s_blue_write;
        wr_color && comp_reg == phpt_pkg::COMP_BLUE;
    endsequence
    property p_widx_inc;
        s_blue_write |=> wr_idx_reg == $past(wr_idx_reg) + 8'h01;
    endproperty
    a_widx_inc: assert property (p_widx_inc) else $error("write index step");

    sequence s_blue_read;
        rd_color && comp_reg == phpt_pkg::COMP_BLUE;
    endsequence
    property p_ridx_inc;
        s_blue_read |=> rd_idx_reg == $past(rd_idx_reg) + 8'h01 && comp_reg == phpt_pkg::COMP_RED;
    endproperty
    a_ridx_inc: assert property (p_ridx_inc) else $error("read index step");

    property p_pix;
        pixel_indexed8 |=> lut_index == ($past(pixel_index) & $past(mask_reg));
    endproperty
    a_pix: assert property (p_pix) else $error("pixel mask not applied");

    property p_ridx_read;
        sel_fall && fall_read && fall_addr == phpt_pkg::REG_RD_INDEX
            |=> rd_data_reg == $past(rd_idx_reg);
    endproperty
    a_ridx_read: assert property (p_ridx_read) else $error("read index readback");

    property p_comp_clr;
        (wr_widx || wr_ridx) |=> comp_reg == phpt_pkg::COMP_RED;
    endproperty
    a_comp_clr: assert property (p_comp_clr) else $error("component not cleared");
endmodule
`default_nettype wire

// file: logic/phpt_lut_if.sv
// Purpose: carrier between the port logic and the lookup table memory
// Assumes: single clock
// Notes: read data is registered inside the memory
`timescale 1ns/100ps
`default_nettype none
interface phpt_lut_if;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [7:0] wr_data;
    logic [9:0] rd_addr;
    logic [7:0] rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: logic/phpt_lut_mem.sv
// Purpose: 256 entry lookup table, one byte per colour component
// Assumes: address is {index, component}
// Notes: contents are not reset, as in the real table
`timescale 1ns/100ps
`default_nettype none
module phpt_lut_mem
(
    input wire logic clk,
    phpt_lut_if.mem lut
);
    // ==========================================================
    // storage
    logic [7:0] mem_reg [0:1023];
    logic [7:0] rdata_reg;

    always_ff @(posedge clk)
    begin
        if (lut.wr_en)
        begin
            mem_reg[lut.wr_addr] <= lut.wr_data;
        end
        rdata_reg <= mem_reg[lut.rd_addr];
    end

    assign lut.rd_data = rdata_reg;
endmodule
`default_nettype wire

// file: logic/phpt_pkg.sv
// Purpose: shared constants of the palette host port
// Assumes: 40 MHz system clock
// Notes: offsets are the 4-bit register codes seen on the bus
package phpt_pkg;
    // ==========================================================
    // register codes
    localparam logic [3:0] REG_WR_INDEX = 4'h0;
    localparam logic [3:0] REG_COLOR = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_RD_INDEX = 4'h3;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // ==========================================================
    // bus field positions
    localparam int ADDR_MSB = 3;
    localparam int DIR_BIT = 7;
    // ==========================================================
    // timing: the pipelined limits scale with the undivided video clock period
    localparam int CLK_PERIOD_NS = 25;
    localparam int DOT_CLOCK_PERIOD_NS = 6;
    localparam int PIPE_RECOVERY_NS = 6 * DOT_CLOCK_PERIOD_NS;
    localparam int PIPE_RECOVERY_CYC =
        (PIPE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================================
    // colour component sequence
    typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} phpt_comp_t;
endpackage

// file: verification/phpt_host_model.sv
// Purpose: host model driving the strobe bus
// Assumes: same clock as the port
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module phpt_host_model
(
    input wire logic clk,
    output logic select_n,
    output logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe
);
    // ==========================================
    // bus resolution
    logic drv_en;
    logic [7:0] drv;
    logic [7:0] last_q = 8'h00;
    assign ad_in = ad_oe ? ad_out : (drv_en ? drv : ~last_q);
    // only a driven value is remembered, so a floating bus holds still
    always @(posedge clk)
        if (drv_en || ad_oe)
            last_q <= ad_in;
    initial
    begin
        select_n = 1'b1;
        drv_en = 1'b0;
        drv = 8'h00;
    end
    // ==========================================
    // one strobe cycle; ok drops when no answer came
    task automatic access(input logic rd, input logic [3:0] a, input logic [7:0] wd,
        output logic [7:0] q, output logic ok);
        int i;
        ok = 1'b1;
        q = 8'h00;
        @(posedge clk);
        select_n <= 1'b0;
        drv_en <= 1'b1;
        drv <= {rd, 3'h0, a};
        repeat (4) @(posedge clk);
        if (!rd)
        begin
            drv <= wd;
            repeat (2) @(posedge clk);
            select_n <= 1'b1;
            // data held until the synced rise is surely seen
            repeat (4) @(posedge clk);
            drv_en <= 1'b0;
        end
        else
        begin
            drv_en <= 1'b0;
            for (i = 0; i < 8 && ad_oe !== 1'b1; i++)
                @(negedge clk);
            ok = (ad_oe === 1'b1);
            q = ad_out;
            @(posedge clk);
            select_n <= 1'b1;
        end
        // generous recovery covers every access kind
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: verification/tb_palette_host_port.sv
// Purpose: self-checking bench of the palette host port
// Assumes: 40 MHz clock, host model on the strobe bus
// Notes: lookup table holes stay unknown, only written entries are read
`timescale 1ns/100ps
`default_nettype none
module tb_palette_host_port;
    logic clk;
    logic rst;
    logic select_n;
    logic [7:0] ad_in;
    logic [7:0] ad_out;
    logic ad_oe;
    logic [7:0] pixel_index;
    logic pixel_indexed8;
    logic [7:0] lut_index;
    int fails;
    int check_count;
    always #12.5 clk = ~clk;
    phpt_host_port i_dut
    (
        .clk(clk),
        .rst(rst),
        .select_n(select_n),
        .ad_in(ad_in),
        .ad_out(ad_out),
        .ad_oe(ad_oe),
        .pixel_index(pixel_index),
        .pixel_indexed8(pixel_indexed8),
        .lut_index(lut_index)
    );
    phpt_host_model i_host
    (
        .clk(clk),
        .select_n(select_n),
        .ad_in(ad_in),
        .ad_out(ad_out),
        .ad_oe(ad_oe)
    );
    // ==========================================
    // helpers
    task automatic end_sim;
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        i_host.access(1'b0, a, d, q, ok);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic ok;
        i_host.access(1'b1, a, 8'h00, q, ok);
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t read never answered", $time);
            end_sim();
        end
        chk8(q, exp);
    endtask
    task automatic pix_chk(input logic m8, input logic [7:0] exp);
        @(posedge clk);
        pixel_index <= 8'hA5;
        pixel_indexed8 <= m8;
        @(posedge clk);
        @(negedge clk);
        chk8(lut_index, exp);
    endtask
    // ==========================================
    // scenarios
    task automatic t_mask;
        rd_chk(phpt_pkg::REG_MASK, phpt_pkg::MASK_RESET);
        wr(phpt_pkg::REG_MASK, 8'h0F);
        rd_chk(phpt_pkg::REG_MASK, 8'h0F);
        pix_chk(1'b1, 8'h05);
        pix_chk(1'b0, 8'hA5);
    endtask
    task automatic t_palette;
        int i;
        wr(phpt_pkg::REG_WR_INDEX, 8'hFE);
        for (i = 0; i < 6; i++)
            wr(phpt_pkg::REG_COLOR, 8'h30 + i[7:0]);
        rd_chk(phpt_pkg::REG_WR_INDEX, 8'h00);
        wr(phpt_pkg::REG_RD_INDEX, 8'hFE);
        for (i = 0; i < 6; i++)
            rd_chk(phpt_pkg::REG_COLOR, 8'h30 + i[7:0]);
        rd_chk(phpt_pkg::REG_RD_INDEX, 8'h00);
    endtask
    task automatic t_reserved;
        int i;
        for (i = 4; i < 8; i++)
        begin
            wr(i[3:0], 8'h00);
            rd_chk(i[3:0], phpt_pkg::READ_ZERO);
        end
        rd_chk(phpt_pkg::REG_MASK, 8'h0F);
    endtask
    task automatic t_partial;
        int i;
        wr(phpt_pkg::REG_WR_INDEX, 8'h20);
        wr(phpt_pkg::REG_COLOR, 8'h11);
        wr(phpt_pkg::REG_WR_INDEX, 8'h20);
        for (i = 0; i < 3; i++)
            wr(phpt_pkg::REG_COLOR, 8'hC0 + i[7:0]);
        wr(phpt_pkg::REG_RD_INDEX, 8'h20);
        rd_chk(phpt_pkg::REG_COLOR, 8'hC0);
        wr(phpt_pkg::REG_RD_INDEX, 8'h20);
        for (i = 0; i < 3; i++)
            rd_chk(phpt_pkg::REG_COLOR, 8'hC0 + i[7:0]);
    endtask
    task automatic t_keep;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(phpt_pkg::REG_WR_INDEX, 8'h21);
        rd_chk(phpt_pkg::REG_RD_INDEX, 8'h21);
        rd_chk(phpt_pkg::REG_MASK, phpt_pkg::MASK_RESET);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        pixel_index = 8'h00;
        pixel_indexed8 = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_mask();
        t_palette();
        t_reserved();
        t_partial();
        t_keep();
        end_sim();
    end
endmodule
`default_nettype wire
